// *** cdhi_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdhi_host_port (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic register_select_line_in,
	input wire logic ctrl_pin5_in,
	input wire logic ctrl_pin6_in,
	input wire logic [7:0] db_in,
	output logic [7:0] db_out,
	output logic db_oe_n_out,
	input wire logic bus_style_strap_in,
	input wire logic reset_pin_strap_a_in,
	input wire logic reset_pin_strap_b_in,
	input wire logic ext_reset_n_in,
	output logic busy_flag_out,
	input wire logic [7:0] glyph_code_in,
	input wire logic [2:0] glyph_line_in,
	output logic [4:0] glyph_dots_out,
	input wire logic scan_row_in,
	input wire logic [4:0] scan_col_in,
	output logic [7:0] scan_code_out
);
	////////////////////////////////////////////////////////////
	cdhi_pkg::cdhi_state_type q;
	cdhi_pkg::cdhi_state_type d;
	logic [7:0] text_mem [0:(1<<cdhi_pkg::TEXT_AW)-1];
	logic [7:0] glyph_mem [0:(1<<cdhi_pkg::GLYPH_AW)-1];
	logic [cdhi_pkg::SY_W-1:0] s;
	logic rst_eff;
	logic wr_act;
	logic rd_act;
	logic wr_fall;
	logic rd_rise;
	logic rd_fall;
	logic rs;
	logic busy;
	logic [7:0] wdat;
	logic [7:0] ram_byte;
	logic [7:0] glyph_word;
	logic [6:0] scan_addr;
	logic txt_we;
	logic glf_we;
	logic [6:0] we_addr;
	logic [7:0] we_data;

	// Codes with a zero upper nibble come from user glyph RAM
	function automatic logic is_user_code(input logic [7:0] c);
		is_user_code = (c[7:4] == cdhi_pkg::USER_CODE_HI);
	endfunction

	// Counter step; glyph addressing wraps inside its 64 bytes
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic g);
		logic [6:0] n;
		n = up ? a + 7'h01 : a - 7'h01;
		if (g) begin
			n[6] = 1'b0;
		end
		step_addr = n;
	endfunction

	// Stand-in pattern generator; a real font table replaces it
	function automatic logic [4:0] rom_dots(input logic [7:0] c, input logic [2:0] l);
		logic [7:0] x;
		x = c >> l[1:0];
		rom_dots = (l == cdhi_pkg::CURSOR_LINE) ? cdhi_pkg::DOTS_RST : (x[4:0] ^ {2'b00, l});
	endfunction

	////////////////////////////////////////////////////////////
	// Pin view after two synchroniser stages
	assign s = q.sy[1];
	assign rs = s[cdhi_pkg::SY_RS];
	assign wdat = s[cdhi_pkg::SY_DB +: 8];
	assign rst_eff = rst_in | (s[cdhi_pkg::SY_SA] & s[cdhi_pkg::SY_SB] & ~s[cdhi_pkg::SY_XR]);
	assign wr_act = s[cdhi_pkg::SY_BUS] ? ~s[cdhi_pkg::SY_P5]
		: (s[cdhi_pkg::SY_P6] & ~s[cdhi_pkg::SY_P5]);
	assign rd_act = s[cdhi_pkg::SY_BUS] ? ~s[cdhi_pkg::SY_P6]
		: (s[cdhi_pkg::SY_P6] & s[cdhi_pkg::SY_P5]);
	assign wr_fall = q.wr_prev & ~wr_act;
	assign rd_rise = rd_act & ~q.rd_prev;
	assign rd_fall = q.rd_prev & ~rd_act;
	assign busy = (q.op != cdhi_pkg::OP_IDLE);
	assign ram_byte = q.glyph_sel ? glyph_mem[q.addr[5:0]] : text_mem[q.addr];
	assign glyph_word = glyph_mem[{glyph_code_in[2:0], glyph_line_in}];
	assign scan_addr = (scan_row_in ? cdhi_pkg::ROW2_BASE : cdhi_pkg::ROW1_BASE)
		+ {2'b00, scan_col_in};

	assign db_out = q.dout;
	assign db_oe_n_out = ~q.drive;
	assign busy_flag_out = busy;
	assign glyph_dots_out = q.dots;
	assign scan_code_out = q.scan;

	////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.sy[0] = {ext_reset_n_in, reset_pin_strap_b_in, reset_pin_strap_a_in, bus_style_strap_in,
			register_select_line_in, ctrl_pin6_in, ctrl_pin5_in, db_in};
		d.sy[1] = q.sy[0];
		d.wr_prev = wr_act;
		d.rd_prev = rd_act;
		d.scan = text_mem[scan_addr];
		d.dots = is_user_code(glyph_code_in) ? glyph_word[4:0]
			: rom_dots(glyph_code_in, glyph_line_in);
		txt_we = 1'b0;
		glf_we = 1'b0;
		we_addr = q.addr;
		we_data = q.stage;
		if (rst_eff) begin
			// Edge history follows the pins so release makes no false edge
			d.op = cdhi_pkg::OP_IDLE;
			d.addr = cdhi_pkg::ADDR_RST;
			d.glyph_sel = 1'b0;
			d.inc = cdhi_pkg::INC_RST;
			d.stage = cdhi_pkg::BYTE_RST;
			d.dout = cdhi_pkg::BYTE_RST;
			d.drive = 1'b0;
			d.clr = cdhi_pkg::ADDR_RST;
			d.dots = cdhi_pkg::DOTS_RST;
			d.scan = cdhi_pkg::BYTE_RST;
		end else begin
			if (rd_rise) begin
				d.drive = 1'b1;
				d.dout = rs ? q.stage : {busy, q.addr};
			end
			if (rd_fall) begin
				d.drive = 1'b0;
			end
			unique case (q.op)
				cdhi_pkg::OP_IDLE: begin
					if (wr_fall && !rs) begin
						// Accepted only while idle; busy host writes are dropped
						d.op = cdhi_pkg::OP_FETCH;
						if (wdat[7]) begin
							d.addr = wdat[6:0];
							d.glyph_sel = 1'b0;
						end else if (wdat[7:6] == cdhi_pkg::CMD_GLYPH_ADDR) begin
							d.addr = {1'b0, wdat[5:0]};
							d.glyph_sel = 1'b1;
						end else if (wdat == cdhi_pkg::CMD_CLEAR) begin
							d.op = cdhi_pkg::OP_CLEAR;
							d.clr = cdhi_pkg::ADDR_RST;
							d.glyph_sel = 1'b0;
						end else if ((wdat & cdhi_pkg::CMD_ENTRY_MASK) == cdhi_pkg::CMD_ENTRY) begin
							d.inc = wdat[cdhi_pkg::ENTRY_INC_BIT];
						end
					end else if (wr_fall && rs) begin
						d.stage = wdat;
						d.op = cdhi_pkg::OP_WRITE;
					end else if (rd_fall && rs) begin
						d.addr = step_addr(q.addr, q.inc, q.glyph_sel);
						d.op = cdhi_pkg::OP_FETCH;
					end
				end
				cdhi_pkg::OP_FETCH: begin
					d.stage = ram_byte;
					d.op = cdhi_pkg::OP_IDLE;
				end
				cdhi_pkg::OP_WRITE: begin
					txt_we = !q.glyph_sel;
					glf_we = q.glyph_sel;
					d.addr = step_addr(q.addr, q.inc, q.glyph_sel);
					d.op = cdhi_pkg::OP_IDLE;
				end
				cdhi_pkg::OP_CLEAR: begin
					txt_we = 1'b1;
					we_addr = q.clr;
					we_data = cdhi_pkg::BLANK_CODE;
					d.clr = q.clr + 7'h01;
					if (q.clr == cdhi_pkg::CLEAR_LAST) begin
						d.addr = cdhi_pkg::ADDR_RST;
						d.op = cdhi_pkg::OP_FETCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q <= '0;
			q.inc <= cdhi_pkg::INC_RST;
		end else begin
			q <= d;
		end
	end

	// Memories hold no reset; contents survive a reset
	always_ff @(posedge ref_clk_in) begin
		if (txt_we) begin
			text_mem[we_addr] <= we_data;
		end
		if (glf_we) begin
			glyph_mem[we_addr[5:0]] <= we_data;
		end
	end

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_eff);

	status_read_a: assert property (rd_rise && !rs |=> q.dout == {$past(busy), $past(q.addr)})
		else $error("status read byte wrong");
	data_read_a: assert property (rd_rise && rs |=> q.dout == $past(q.stage) && q.drive)
		else $error("data read byte wrong");
	addr_load_a: assert property (wr_fall && !rs && !busy && wdat[7]
		|=> q.addr == $past(wdat[6:0]) && !q.glyph_sel ##1 q.stage == $past(ram_byte))
		else $error("address load or fetch wrong");
	prefetch_next_a: assert property (rd_fall && rs && !busy |=> q.op == cdhi_pkg::OP_FETCH)
		else $error("no prefetch after read");
	counter_up_a: assert property (rd_fall && rs && !busy && q.inc && !q.glyph_sel
		|=> q.addr == $past(q.addr) + 7'h01)
		else $error("counter step wrong");
	busy_raise_a: assert property (wr_fall && !busy |=> busy)
		else $error("busy not raised");
	busy_instr_a: assert property (wr_fall && !rs && busy
		|=> $stable(q.inc) && $stable(q.glyph_sel))
		else $error("instruction taken while busy");
	clear_end_a: assert property (q.op == cdhi_pkg::OP_CLEAR && q.clr == cdhi_pkg::CLEAR_LAST
		|=> q.op == cdhi_pkg::OP_FETCH && q.addr == cdhi_pkg::ADDR_RST ##1 !busy)
		else $error("clear did not finish");
	user_glyph_a: assert property (is_user_code(glyph_code_in) |=> q.dots == $past(glyph_word[4:0]))
		else $error("user glyph lookup wrong");
	write_store_a: assert property (q.op == cdhi_pkg::OP_WRITE |-> (txt_we ^ glf_we) && we_data == q.stage)
		else $error("data write not stored");

	// Instruction decode
	glyph_load_a: assert property (wr_fall && !rs && !busy && wdat[7:6] == cdhi_pkg::CMD_GLYPH_ADDR
		|=> q.glyph_sel && q.addr == {1'b0, $past(wdat[5:0])})
		else $error("glyph address load wrong");
	entry_set_a: assert property (wr_fall && !rs && !busy && (wdat & cdhi_pkg::CMD_ENTRY_MASK) == cdhi_pkg::CMD_ENTRY
		|=> q.inc == $past(wdat[cdhi_pkg::ENTRY_INC_BIT]))
		else $error("step direction not taken");
	clear_start_a: assert property (wr_fall && !rs && !busy && wdat == cdhi_pkg::CMD_CLEAR
		|=> q.op == cdhi_pkg::OP_CLEAR && q.clr == cdhi_pkg::ADDR_RST)
		else $error("clear did not start");

	// Counter and RAM transfer sequencing
	clear_fill_a: assert property (q.op == cdhi_pkg::OP_CLEAR |-> txt_we && !glf_we && we_addr == q.clr && we_data == cdhi_pkg::BLANK_CODE)
		else $error("clear fill wrong");
	clear_step_a: assert property (q.op == cdhi_pkg::OP_CLEAR && q.clr != cdhi_pkg::CLEAR_LAST
		|=> q.op == cdhi_pkg::OP_CLEAR && q.clr == $past(q.clr) + 7'h01)
		else $error("clear step wrong");
	write_up_a: assert property (q.op == cdhi_pkg::OP_WRITE && q.inc && !q.glyph_sel
		|=> q.addr == $past(q.addr) + 7'h01)
		else $error("write step up wrong");
	write_down_a: assert property (q.op == cdhi_pkg::OP_WRITE && !q.inc
		|=> q.addr[5:0] == $past(q.addr[5:0]) - 6'h01)
		else $error("write step down wrong");
	counter_down_a: assert property (rd_fall && rs && !busy && !q.inc && !q.glyph_sel
		|=> q.addr == $past(q.addr) - 7'h01)
		else $error("read step down wrong");
	glyph_wrap_a: assert property (q.op == cdhi_pkg::OP_WRITE && q.glyph_sel |=> !q.addr[6])
		else $error("glyph address left its range");
	glyph_store_a: assert property (q.op == cdhi_pkg::OP_WRITE && q.glyph_sel |-> glf_we && !txt_we)
		else $error("glyph write went astray");
	sel_keep_a: assert property (q.op == cdhi_pkg::OP_WRITE |=> $stable(q.glyph_sel))
		else $error("RAM target changed by write");
	fetch_done_a: assert property (q.op == cdhi_pkg::OP_FETCH |=> q.op == cdhi_pkg::OP_IDLE)
		else $error("fetch did not end");
	write_done_a: assert property (q.op == cdhi_pkg::OP_WRITE |=> q.op == cdhi_pkg::OP_IDLE)
		else $error("write did not end");
	store_gate_a: assert property (q.op != cdhi_pkg::OP_WRITE && q.op != cdhi_pkg::OP_CLEAR |-> !txt_we && !glf_we)
		else $error("RAM written outside a transfer");
	clear_hold_a: assert property (wr_fall && rs && q.op == cdhi_pkg::OP_CLEAR |=> $stable(q.stage))
		else $error("data taken during clear");
	idle_stable_a: assert property (q.op == cdhi_pkg::OP_IDLE && !wr_fall && !rd_fall
		|=> q.op == cdhi_pkg::OP_IDLE && $stable(q.addr))
		else $error("idle state moved by itself");

	// Read drive window; the bus is let go the cycle after the synchronised strobe ends
	read_drive_a: assert property (rd_rise |=> q.drive)
		else $error("read not driven");
	drive_release_a: assert property (rd_fall |=> !q.drive)
		else $error("bus not released");
	drive_hold_a: assert property (q.drive && !rd_fall |=> q.drive)
		else $error("bus dropped during read");

	// Display side
	rom_blank_a: assert property (!is_user_code(glyph_code_in) && glyph_line_in == cdhi_pkg::CURSOR_LINE
		|=> q.dots == cdhi_pkg::DOTS_RST)
		else $error("cursor line not blank");

	instr_cover_c: cover property (wr_fall && !rs && !busy);
	data_read_c: cover property (rd_fall && rs ##[1:4] rd_rise && rs);
	clear_done_c: cover property (q.op == cdhi_pkg::OP_CLEAR && q.clr == cdhi_pkg::CLEAR_LAST);
	glyph_write_c: cover property (glf_we);
	down_write_c: cover property (q.op == cdhi_pkg::OP_WRITE && !q.inc);
endmodule // cdhi_host_port
`default_nettype wire

// *** cdhi_pkg.sv ***
package cdhi_pkg;
	localparam int SY_W = 15;
	localparam int SY_DB = 0;
	localparam int SY_P5 = 8;
	localparam int SY_P6 = 9;
	localparam int SY_RS = 10;
	localparam int SY_BUS = 11;
	localparam int SY_SA = 12;
	localparam int SY_SB = 13;
	localparam int SY_XR = 14;
	localparam int TEXT_AW = 7;
	localparam int GLYPH_AW = 6;
	localparam int ENTRY_INC_BIT = 1;
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam logic [7:0] CMD_ENTRY_MASK = 8'hFC;
	localparam logic [7:0] CMD_ENTRY = 8'h04;
	localparam logic [1:0] CMD_GLYPH_ADDR = 2'h1;
	localparam logic [7:0] BLANK_CODE = 8'h20;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [6:0] ROW1_BASE = 7'h00;
	localparam logic [6:0] ROW2_BASE = 7'h40;
	localparam logic [6:0] CLEAR_LAST = 7'h7F;
	localparam logic INC_RST = 1'b1;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [4:0] DOTS_RST = 5'h00;
	localparam logic [3:0] USER_CODE_HI = 4'h0;
	localparam logic [2:0] CURSOR_LINE = 3'h7;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_FETCH = 2'b01,
		OP_WRITE = 2'b11,
		OP_CLEAR = 2'b10
	} cdhi_op_type;

	typedef struct packed {
		logic [1:0][SY_W-1:0] sy;
		logic wr_prev;
		logic rd_prev;
		cdhi_op_type op;
		logic [6:0] addr;
		logic glyph_sel;
		logic inc;
		logic [7:0] stage;
		logic [7:0] dout;
		logic drive;
		logic [6:0] clr;
		logic [4:0] dots;
		logic [7:0] scan;
	} cdhi_state_type;
endpackage

// *** cdhi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdhi_host_model (
	input wire logic ref_clk_in,
	input wire logic i80_in,
	input wire logic [7:0] dev_db_in,
	input wire logic dev_oe_n_in,
	output logic rs_out,
	output logic pin5_out,
	output logic pin6_out,
	output logic [7:0] db_out,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out
);
	logic stb = 1'h0;
	logic rw = 1'h0;
	initial begin
		rs_out = 1'h0;
		db_out = 8'h00;
		rd_valid_out = 1'h0;
		rd_data_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// Idle levels follow the strap, so a style change never leaves a strobe active
	assign pin5_out = i80_in ? ~(stb & ~rw) : rw;
	assign pin6_out = i80_in ? ~(stb & rw) : stb;
	// Four clocks of setup and six of hold cover the 2-FF sampling of every pin
	task automatic access(input logic rs, input logic rd, input logic [7:0] wd);
		@(posedge ref_clk_in);
		rs_out <= rs;
		rw <= rd;
		db_out <= rd ? ~db_out : wd;
		repeat (4) @(posedge ref_clk_in);
		stb <= 1'h1;
		repeat (6) @(posedge ref_clk_in);
		if (rd && dev_oe_n_in === 1'h0) begin
			rd_valid_out <= 1'h1;
			rd_data_out <= dev_db_in;
		end
		stb <= 1'h0;
		@(posedge ref_clk_in);
		rd_valid_out <= 1'h0;
		repeat (5) @(posedge ref_clk_in);
	endtask
endmodule // cdhi_host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk_in = 1'h0;
	logic rst_in, rs, p5, p6, oe_n, strap, sa, sb, ext_n, busy, srow, rv;
	logic [7:0] db_h, db_d, gcode, scode, rdat;
	logic [2:0] gline;
	logic [4:0] gdots, scol;
	logic [7:0] b [0:2];
	logic [7:0] exp_q [$];
	int seed, mismatches, check_count;
	initial begin
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	cdhi_host_port dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .register_select_line_in(rs),
		.ctrl_pin5_in(p5), .ctrl_pin6_in(p6), .db_in(db_h), .db_out(db_d), .db_oe_n_out(oe_n),
		.bus_style_strap_in(strap), .reset_pin_strap_a_in(sa), .reset_pin_strap_b_in(sb),
		.ext_reset_n_in(ext_n), .busy_flag_out(busy), .glyph_code_in(gcode), .glyph_line_in(gline),
		.glyph_dots_out(gdots), .scan_row_in(srow), .scan_col_in(scol), .scan_code_out(scode));
	cdhi_host_model host (.ref_clk_in(ref_clk_in), .i80_in(strap), .dev_db_in(db_d), .dev_oe_n_in(oe_n),
		.rs_out(rs), .pin5_out(p5), .pin6_out(p6), .db_out(db_h), .rd_valid_out(rv), .rd_data_out(rdat));
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] got);
		check_count++;
		if (got !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic wr(input logic r, input logic [7:0] v);
		host.access(r, 1'h0, v);
	endtask
	task automatic rd(input logic r, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(r, 1'h1, 8'h00);
	endtask
	task automatic ext_pulse();
		ext_n <= 1'h0;
		repeat (6) @(posedge ref_clk_in);
		ext_n <= 1'h1;
	endtask
	// Every read byte is matched to the oldest expectation
	always @(posedge ref_clk_in) begin
		if (rv === 1'h1) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("mismatch read byte expected none seen %h", rdat);
			end else begin
				cmp("read byte", exp_q.pop_front(), rdat);
			end
		end
	end
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		mismatches++;
		$display("mismatch run length expected done seen timeout");
		close_out();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rst_in = 1'h1; strap = 1'h0; sa = 1'h0; sb = 1'h0; ext_n = 1'h1;
		// Built-in code first: unwritten glyph RAM would read unknown
		gcode = 8'h20; gline = 3'h7; srow = 1'h0; scol = 5'h00; seed = 79;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		rd(1'h0, 8'h00);
		// Blank the text RAM so that no text RAM fetch returns an unwritten byte
		wr(1'h0, 8'h01);
		repeat (140) @(posedge ref_clk_in);
		wr(1'h0, 8'h85);
		rd(1'h0, 8'h05);
		for (int i = 0; i < 3; i++) begin
			b[i] = 8'($random(seed));
			wr(1'h1, b[i]);
		end
		rd(1'h0, 8'h08);
		wr(1'h0, 8'h85);
		for (int i = 0; i < 3; i++) rd(1'h1, b[i]);
		rd(1'h0, 8'h08);
		wr(1'h0, 8'h04);
		wr(1'h0, 8'h90);
		wr(1'h1, b[0]);
		rd(1'h0, 8'h0F);
		wr(1'h0, 8'h01);
		wr(1'h1, 8'hEE);
		wr(1'h0, 8'h06);
		cmp("busy flag", 8'h01, {7'h00, busy});
		// Clear keeps busy for 129 cycles, so the host waits that out
		repeat (140) @(posedge ref_clk_in);
		cmp("busy flag", 8'h00, {7'h00, busy});
		wr(1'h0, 8'h84);
		wr(1'h0, 8'h80);
		rd(1'h1, 8'h20);
		wr(1'h0, 8'hC0);
		wr(1'h1, b[1]);
		srow <= 1'h1;
		repeat (3) @(posedge ref_clk_in);
		cmp("scan code", b[1], scode);
		wr(1'h0, 8'hFF);
		wr(1'h1, b[2]);
		wr(1'h0, 8'hFF);
		rd(1'h1, b[2]);
		wr(1'h0, 8'h53);
		wr(1'h1, 8'h15);
		gcode <= 8'h0A;
		gline <= 3'h3;
		repeat (3) @(posedge ref_clk_in);
		cmp("glyph dots", 8'h15, {3'h0, gdots});
		wr(1'h0, 8'h53);
		rd(1'h1, 8'h15);
		wr(1'h0, 8'h85);
		sa <= 1'h1;
		ext_pulse();
		rd(1'h0, 8'h05);
		sb <= 1'h1;
		ext_pulse();
		rd(1'h0, 8'h00);
		strap <= 1'h1;
		rst_in <= 1'h1;
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		wr(1'h0, 8'h83);
		rd(1'h0, 8'h03);
		repeat (10) @(posedge ref_clk_in);
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("mismatch reads left expected %0d seen %0d", 0, exp_q.size());
		end
		close_out();
	end
endmodule // testbench
`default_nettype wire
